/* File: rtl/gt2_defs.svh */
`ifndef GT2_DEFS_SVH
`define GT2_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GT2_OFF_CTRL    8'h00
`define GT2_OFF_CLKSEL  8'h04
`define GT2_OFF_RLD_LO  8'h08
`define GT2_OFF_RLD_HI  8'h0c
`define GT2_OFF_CNT_LO  8'h10
`define GT2_OFF_CNT_HI  8'h14
`define GT2_OFF_POWER   8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GT2_B_HOF       7
`define GT2_B_LOF       6
`define GT2_B_LIE       5
`define GT2_B_CAP       4
`define GT2_B_SPLIT     3
`define GT2_B_RUN       2
`define GT2_B_UNUSED    1
`define GT2_B_XSEL      0
`define GT2_B_LSEL      0
`define GT2_B_HSEL      1
`define GT2_B_TIE       2
`define GT2_B_SUSP      0
`define GT2_B_SYNCP     1

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define GT2_BYTE_RST    8'h00
`define GT2_DIV_SYS     4'd12
`define GT2_DIV_EXT     4'd8
`define GT2_SYNC_TICKS  2'd3

`endif

/* File: rtl/gt2_pkg.sv */
package gt2_pkg;

   typedef enum logic [1:0] {
      GT2_ACTIVE  = 2'b00,
      GT2_SUSPEND = 2'b01,
      GT2_SYNCING = 2'b10
   } gt2_power_t;

endpackage : gt2_pkg

/* File: rtl/gt2_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gt2_defs.svh"

module gt2_prescale (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic ext_osc,
   output logic      tick_div12,
   output logic      ext_div8
);

   logic [3:0] div12_r;
   logic [3:0] ext_cnt_r;
   logic       ext_prev_r;
   logic       ext_div8_r;
   logic       tick_r;

   wire ext_rise  = ext_osc & ~ext_prev_r;
   wire div12_end = (div12_r == `GT2_DIV_SYS - 4'd1);
   // Divided clock toggles every half period of external edges
   wire half_end  = (ext_cnt_r == (`GT2_DIV_EXT >> 1) - 4'd1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div12_r    <= 4'h0;
         tick_r     <= 1'b0;
         ext_prev_r <= 1'b0;
         ext_cnt_r  <= 4'h0;
         ext_div8_r <= 1'b0;
      end else begin
         div12_r    <= div12_end ? 4'h0 : div12_r + 4'd1;
         tick_r     <= div12_end;
         ext_prev_r <= ext_osc;
         if (ext_rise) begin
            ext_cnt_r <= half_end ? 4'h0 : ext_cnt_r + 4'd1;
            if (half_end)
               ext_div8_r <= ~ext_div8_r;
         end
      end
   end

   assign tick_div12 = tick_r;
   assign ext_div8   = ext_div8_r;

endmodule : gt2_prescale

`default_nettype wire

/* File: rtl/gt2_sync_edge.sv */
`timescale 1ns/1ps
`default_nettype none

module gt2_sync_edge (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic din,
   output logic      rise
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // First stage feeds only the second stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign rise = sync_r & ~prev_r;

endmodule : gt2_sync_edge

`default_nettype wire

/* File: rtl/gt2_timer.sv */
// Notes on behaviour
// - Counter is two bytes; split bit picks one 16-bit or two 8-bit.
// - Count clock is system clock, system clock /12, or external /8.
// - External /8 is synchronised except in suspend, where it is direct.
// - Timer counts through suspend; a high byte overflow ends suspend.
// - Other wake source holds sync pending until the third external /8 edge.
// - 16-bit wrap from ffff loads reload pair and sets high flag.
// - 16-bit mode: timer irq enable raises irq on each full overflow.
// - 16-bit mode: low irq enable adds irq on low byte rollover.
// - Split mode: each byte auto-reloads from its own reload byte.
// - Split mode: run bit gates only the high byte.
// - Per-byte select: 1 system clock, else /12 or external /8.
// - Split mode: high rollover sets high flag, low sets low flag.
// - Split mode: irq on high overflow, plus low when low enable set.
// - Hardware never clears overflow flags; software clears, checks both.
// - Capture active only with capture bit 1, split 0; no external clock.
// - Comparator rising edge copies count to reload, sets high flag.
// - Unused control bit 1 reads zero; writes ignored.
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gt2_defs.svh"

module gt2_timer
   import gt2_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        ext_osc,
   input  wire logic        comparator_out,
   input  wire logic        wake_other,
   output logic             timer_irq,
   output logic             suspended,
   output logic             wake_event
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic src_tick(input logic sel, input logic xsel,
                                     input logic cap, input logic t12,
                                     input logic tx);
      src_tick = sel ? 1'b1 : ((xsel & ~cap) ? tx : t12);
   endfunction : src_tick

   function automatic logic reg_hit(input logic pend,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
      reg_hit = pend & (a == off);
   endfunction : reg_hit

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_r;
   logic [2:0]  clksel_r;
   logic [7:0]  rld_lo_r;
   logic [7:0]  rld_hi_r;
   logic [7:0]  cnt_lo_r;
   logic [7:0]  cnt_hi_r;
   logic [31:0] hrdata_r;
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic [1:0]  sync_cnt_r;
   logic        ext_prev_r;
   logic        wake_r;
   gt2_power_t  pwr_r;
   gt2_power_t  pwr_nxt;

   // ----------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------
   logic tick_div12;
   logic ext_div8;
   logic ext_sync_rise;
   logic cmp_rise;

   gt2_prescale u_pre (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .ext_osc    (ext_osc),
      .tick_div12 (tick_div12),
      .ext_div8   (ext_div8)
   );

   gt2_sync_edge u_ext_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .din     (ext_div8),
      .rise    (ext_sync_rise)
   );

   gt2_sync_edge u_cmp_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .din     (comparator_out),
      .rise    (cmp_rise)
   );

   wire in_susp     = (pwr_r == GT2_SUSPEND);
   wire ext_raw     = ext_div8 & ~ext_prev_r;
   // Suspend skips the synchroniser delay so the wake is not lost
   wire ext_tick    = in_susp ? ext_raw : ext_sync_rise;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   wire split_sel   = ctrl_r[`GT2_B_SPLIT];
   wire run_ctl     = ctrl_r[`GT2_B_RUN];
   wire xsel        = ctrl_r[`GT2_B_XSEL];
   wire cap_mode    = ctrl_r[`GT2_B_CAP] & ~split_sel;
   wire cap_evt     = cap_mode & cmp_rise;

   wire lo_src = src_tick(clksel_r[`GT2_B_LSEL], xsel, cap_mode,
                          tick_div12, ext_tick);
   wire hi_src = src_tick(clksel_r[`GT2_B_HSEL], xsel, cap_mode,
                          tick_div12, ext_tick);

   wire step16  = ~split_sel & run_ctl & lo_src;
   wire lo_ff   = (cnt_lo_r == 8'hff);
   wire hi_ff   = (cnt_hi_r == 8'hff);
   wire step_lo = split_sel ? lo_src : step16;
   wire step_hi = split_sel ? (hi_src & run_ctl)
                            : (step16 & lo_ff);
   wire lo_wrap = step_lo & lo_ff;
   wire hi_wrap = step_hi & hi_ff;
   // Low byte reloads alone only in split mode
   wire lo_load = lo_wrap & (split_sel | hi_wrap);

   wire [7:0] lo_cnt = lo_load ? rld_lo_r : cnt_lo_r + 8'd1;
   wire [7:0] hi_cnt = hi_wrap ? rld_hi_r : cnt_hi_r + 8'd1;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire addr_ok  = hsel & hready & htrans[1];
   wire wr_ctrl  = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_CTRL);
   wire wr_csel  = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_CLKSEL);
   wire wr_rlo   = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_RLD_LO);
   wire wr_rhi   = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_RLD_HI);
   wire wr_clo   = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_CNT_LO);
   wire wr_chi   = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_CNT_HI);
   wire wr_pwr   = reg_hit(wr_pend_r, wr_addr_r, `GT2_OFF_POWER);
   wire [7:0] wb = hwdata[7:0];
   wire [7:0] ra = haddr[7:0];
   wire sync_p   = (pwr_r == GT2_SYNCING);

   wire [7:0] rd_byte =
      (ra == `GT2_OFF_CTRL)   ? ctrl_r :
      (ra == `GT2_OFF_CLKSEL) ? {5'h00, clksel_r} :
      (ra == `GT2_OFF_RLD_LO) ? rld_lo_r :
      (ra == `GT2_OFF_RLD_HI) ? rld_hi_r :
      (ra == `GT2_OFF_CNT_LO) ? cnt_lo_r :
      (ra == `GT2_OFF_CNT_HI) ? cnt_hi_r :
      (ra == `GT2_OFF_POWER)  ? {6'h00, sync_p, in_susp} :
      8'h00;

   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   // Hardware set beats a software clear in the same cycle
   wire hof_set = hi_wrap | cap_evt;
   wire hof_nxt = hof_set |
                  (wr_ctrl ? wb[`GT2_B_HOF] : ctrl_r[`GT2_B_HOF]);
   wire lof_nxt = lo_wrap |
                  (wr_ctrl ? wb[`GT2_B_LOF] : ctrl_r[`GT2_B_LOF]);
   wire [5:0] cfg_nxt = wr_ctrl ? wb[5:0] : ctrl_r[5:0];
   wire [7:0] ctrl_nxt = {hof_nxt, lof_nxt, cfg_nxt[5:2],
                          1'b0, cfg_nxt[0]};

   wire [7:0] cnt_lo_nxt = wr_clo ? wb :
                           (step_lo ? lo_cnt : cnt_lo_r);
   wire [7:0] cnt_hi_nxt = wr_chi ? wb :
                           (step_hi ? hi_cnt : cnt_hi_r);
   // A capture on the same cycle as a reload write takes priority
   wire [7:0] rld_lo_nxt = cap_evt ? cnt_lo_r :
                           (wr_rlo ? wb : rld_lo_r);
   wire [7:0] rld_hi_nxt = cap_evt ? cnt_hi_r :
                           (wr_rhi ? wb : rld_hi_r);

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         GT2_ACTIVE: begin
            if (wr_pwr && wb[`GT2_B_SUSP])
               pwr_nxt = GT2_SUSPEND;
         end
         GT2_SUSPEND: begin
            if (hi_wrap)
               pwr_nxt = GT2_ACTIVE;
            else if (wake_other)
               pwr_nxt = GT2_SYNCING;
         end
         GT2_SYNCING: begin
            if (ext_raw && sync_cnt_r == `GT2_SYNC_TICKS - 2'd1)
               pwr_nxt = GT2_ACTIVE;
         end
         default: pwr_nxt = GT2_ACTIVE;
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_ok & hwrite;
         if (addr_ok)
            wr_addr_r <= ra;
         if (addr_ok && !hwrite)
            hrdata_r <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r   <= `GT2_BYTE_RST;
         clksel_r <= 3'h0;
         rld_lo_r <= `GT2_BYTE_RST;
         rld_hi_r <= `GT2_BYTE_RST;
         cnt_lo_r <= `GT2_BYTE_RST;
         cnt_hi_r <= `GT2_BYTE_RST;
      end else begin
         ctrl_r   <= ctrl_nxt;
         clksel_r <= wr_csel ? wb[2:0] : clksel_r;
         rld_lo_r <= rld_lo_nxt;
         rld_hi_r <= rld_hi_nxt;
         cnt_lo_r <= cnt_lo_nxt;
         cnt_hi_r <= cnt_hi_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwr_r      <= GT2_ACTIVE;
         sync_cnt_r <= 2'd0;
         ext_prev_r <= 1'b0;
         wake_r     <= 1'b0;
      end else begin
         pwr_r      <= pwr_nxt;
         ext_prev_r <= ext_div8;
         wake_r     <= in_susp & (pwr_nxt == GT2_ACTIVE);
         if (!sync_p)
            sync_cnt_r <= 2'd0;
         else if (ext_raw)
            sync_cnt_r <= sync_cnt_r + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
   assign suspended = in_susp;
   assign wake_event = wake_r;
   // Same equation serves both modes: low flag only counts when enabled
   assign timer_irq = clksel_r[`GT2_B_TIE] &
                      (ctrl_r[`GT2_B_HOF] |
                       (ctrl_r[`GT2_B_LIE] & ctrl_r[`GT2_B_LOF]));

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_wrap_reload: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hi_wrap && lo_wrap && !split_sel && !wr_clo && !wr_chi)
         |=> (cnt_lo_r == $past(rld_lo_r)) &&
             (cnt_hi_r == $past(rld_hi_r)) && ctrl_r[`GT2_B_HOF])
      else $error("16-bit wrap did not reload");

   a_split_gate: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (split_sel && !run_ctl && !wr_chi) |=> $stable(cnt_hi_r))
      else $error("high byte moved while stopped in split mode");

   a_low_free: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (split_sel && !run_ctl && lo_src && !wr_clo && !lo_ff)
         |=> cnt_lo_r == $past(cnt_lo_r) + 8'd1)
      else $error("low byte stalled in split mode");

   a_capture_copy: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cap_evt |=> (rld_lo_r == $past(cnt_lo_r)) &&
                  (rld_hi_r == $past(cnt_hi_r)) && ctrl_r[`GT2_B_HOF])
      else $error("capture did not copy count");

   a_flag_sticky: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (ctrl_r[`GT2_B_HOF] && !wr_ctrl) ##1 !wr_ctrl
         |-> ctrl_r[`GT2_B_HOF])
      else $error("high flag cleared by hardware");

   a_unused_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_ok && !hwrite && ra == `GT2_OFF_CTRL)
         |=> hrdata_r[`GT2_B_UNUSED] == 1'b0)
      else $error("unused control bit read as one");

   a_wake_overflow: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (in_susp && hi_wrap) |=> !suspended && wake_event)
      else $error("overflow did not end suspend");

   a_sync_pending: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (in_susp && !hi_wrap && wake_other) |=> sync_p ##1 sync_p)
      else $error("sync pending not raised after wake");

   a_irq_follow: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (hof_set && clksel_r[`GT2_B_TIE] && !wr_csel) |=> timer_irq)
      else $error("overflow did not raise interrupt");

endmodule : gt2_timer

`default_nettype wire

/* File: verif/test_general_timer_two_autoreload.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gt2_defs.svh"

`define TB_CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin \
   err_count++; $display("Error at %0t: got %h expected %h", $time, \
   (act), (exp)); end end

module test_general_timer_two_autoreload;

   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, ec;
   logic        ext_osc, comparator_out, wake_other;
   logic        timer_irq, suspended, wake_event;
   logic [7:0]  rl, rh, ca, cb;
   logic        woke;
   logic [15:0] c1, c2;
   int          err_count, check_count, gap;

   gt2_timer gt2_timer_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .ext_osc(ext_osc), .comparator_out(comparator_out),
      .wake_other(wake_other), .timer_irq(timer_irq),
      .suspended(suspended), .wake_event(wake_event));

   // ------------------------------------------------------------
   // Clock and free-running external oscillator, 4 hclk period
   // ------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Held low through reset so the oscillator starts from a known phase
   always @(posedge hclk) begin
      ec      <= hresetn ? ec + 3'd1 : 3'd0;
      ext_osc <= hresetn & ec[1];
   end

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task wait_rdy;
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask : wait_rdy

   task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      wait_rdy;
      rd = hrdata;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rdx(input logic [7:0] a);
      xfer(1'b0, a, 8'h00);
   endtask : rdx

   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   task set_cnt(input logic [7:0] lo, input logic [7:0] hi);
      wr(`GT2_OFF_CNT_LO, lo);
      wr(`GT2_OFF_CNT_HI, hi);
   endtask : set_cnt

   task done(input string name);
      $display("test %s done", name);
   endtask : done

   function automatic logic in_rng(logic [31:0] v, int lo, int hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_rng

   // Software view of a period: later capture minus earlier one
   function automatic logic [15:0] cap_gap(logic [15:0] a, logic [15:0] b);
      return b - a;
   endfunction : cap_gap

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up

   // Whole sequence takes under two thousand cycles
   initial begin
      repeat (40000) @(posedge hclk);
      err_count++;
      wrap_up;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      hresetn        = 1'b0;
      hsel           = 1'b0;
      haddr          = '0;
      htrans         = 2'b00;
      hwrite         = 1'b0;
      hsize          = 3'b010;
      hwdata         = '0;
      comparator_out = 1'b0;
      wake_other     = 1'b0;
      err_count      = 0;
      check_count    = 0;
      gap            = 0;
      void'($urandom(89));
      cyc(8);
      hresetn <= 1'b1;

      // Reset values, unmapped place, unused control bit
      for (int a = 0; a <= 8'h1c; a += 4) begin
         rdx(a[7:0]);
         `TB_CHK(rd, 32'h0)
      end
      `TB_CHK({hresp, timer_irq, suspended, wake_event}, 4'h0)
      wr(8'h1c, 8'hff);
      rdx(8'h1c);
      `TB_CHK(rd, 32'h0)
      wr(`GT2_OFF_CTRL, 8'h02);
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd, 32'h0)
      done("reset");

      // 16-bit overflow on system clock
      rl = 8'($urandom) & 8'h7f;
      rh = 8'($urandom);
      wr(`GT2_OFF_RLD_LO, rl);
      wr(`GT2_OFF_RLD_HI, rh);
      set_cnt(8'hfe, 8'hff);
      wr(`GT2_OFF_CLKSEL, 8'h05);
      wr(`GT2_OFF_CTRL, 8'h04);
      cyc(20);
      wr(`GT2_OFF_CTRL, 8'h80);
      rdx(`GT2_OFF_CNT_HI);
      `TB_CHK(rd, {24'h0, rh})
      rdx(`GT2_OFF_CNT_LO);
      `TB_CHK(in_rng(rd, rl, rl + 30), 1'b1)
      cyc(50);
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd, 32'h80)
      `TB_CHK(timer_irq, 1'b1)
      wr(`GT2_OFF_CTRL, 8'h00);
      cyc(2);
      `TB_CHK(timer_irq, 1'b0)
      done("wrap16");

      // Low byte rollover in 16-bit mode
      set_cnt(8'hf8, 8'h00);
      wr(`GT2_OFF_CTRL, 8'h24);
      cyc(20);
      wr(`GT2_OFF_CTRL, 8'h60);
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd, 32'h60)
      `TB_CHK(timer_irq, 1'b1)
      wr(`GT2_OFF_CTRL, 8'h40);
      cyc(2);
      `TB_CHK(timer_irq, 1'b0)
      done("low16");

      // Split mode: low byte runs with run bit clear
      wr(`GT2_OFF_CLKSEL, 8'h07);
      set_cnt(8'hf0, 8'h55);
      wr(`GT2_OFF_CTRL, 8'h08);
      cyc(40);
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd, 32'h48)
      rdx(`GT2_OFF_CNT_HI);
      `TB_CHK(rd, 32'h55)
      rdx(`GT2_OFF_CNT_LO);
      `TB_CHK(in_rng(rd, rl, 8'hff), 1'b1)
      `TB_CHK(timer_irq, 1'b0)
      wr(`GT2_OFF_CTRL, 8'h68);
      cyc(2);
      `TB_CHK(timer_irq, 1'b1)
      rh = 8'($urandom) & 8'h7f;
      wr(`GT2_OFF_RLD_HI, rh);
      wr(`GT2_OFF_CNT_HI, 8'hfe);
      wr(`GT2_OFF_CTRL, 8'h0c);
      cyc(6);
      wr(`GT2_OFF_CTRL, 8'h88);
      rdx(`GT2_OFF_CNT_HI);
      `TB_CHK(in_rng(rd, rh, rh + 12), 1'b1)
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd[7], 1'b1)
      `TB_CHK(timer_irq, 1'b1)
      done("split");

      // Divided clocks: /12 then external /8 (32 hclk per tick)
      wr(`GT2_OFF_CTRL, 8'h00);
      wr(`GT2_OFF_CLKSEL, 8'h00);
      // Third pass: split, high byte on its own /12 select
      for (int k = 0; k < 3; k++) begin
         set_cnt(8'h00, 8'h00);
         wr(`GT2_OFF_CTRL, (k == 1) ? 8'h05 : ((k == 2) ? 8'h0c : 8'h04));
         cyc((k == 1) ? 320 : 120);
         wr(`GT2_OFF_CTRL, 8'h00);
         rdx(`GT2_OFF_CNT_LO);
         `TB_CHK(in_rng(rd, 9, 11), 1'b1)
         rdx(`GT2_OFF_CNT_HI);
         `TB_CHK(in_rng(rd, 9 * (k / 2), 11 * (k / 2)), 1'b1)
      end
      done("divide");

      // Capture of a stopped count, then refusals
      ca = 8'($urandom);
      cb = 8'($urandom);
      wr(`GT2_OFF_CLKSEL, 8'h04);
      set_cnt(ca, cb);
      wr(`GT2_OFF_CTRL, 8'h10);
      cyc(8);
      comparator_out <= 1'b1;
      cyc(8);
      rdx(`GT2_OFF_RLD_LO);
      `TB_CHK(rd, {24'h0, ca})
      rdx(`GT2_OFF_RLD_HI);
      `TB_CHK(rd, {24'h0, cb})
      rdx(`GT2_OFF_CTRL);
      `TB_CHK(rd, 32'h90)
      `TB_CHK(timer_irq, 1'b1)
      set_cnt(~ca, ~cb);
      cyc(8);
      rdx(`GT2_OFF_RLD_LO);
      `TB_CHK(rd, {24'h0, ca})
      comparator_out <= 1'b0;
      wr(`GT2_OFF_CTRL, 8'h18);
      cyc(8);
      comparator_out <= 1'b1;
      cyc(8);
      rdx(`GT2_OFF_RLD_LO);
      `TB_CHK(rd, {24'h0, ca})
      comparator_out <= 1'b0;
      // Period between two comparator edges, counted on the system clock
      gap = 16 + ($urandom & 32'hff);
      wr(`GT2_OFF_CLKSEL, 8'h05);
      set_cnt(8'h00, 8'h00);
      wr(`GT2_OFF_CTRL, 8'h14);
      for (int e = 0; e < 2; e++) begin
         comparator_out <= 1'b1;
         cyc(4);
         comparator_out <= 1'b0;
         rdx(`GT2_OFF_RLD_LO);
         c2[7:0] = rd[7:0];
         rdx(`GT2_OFF_RLD_HI);
         c2[15:8] = rd[7:0];
         if (e == 0) begin
            c1 = c2;
            cyc(gap - 8);
         end
      end
      `TB_CHK(cap_gap(c1, c2), gap[15:0])
      done("capture");

      // Suspend: overflow on external clock ends it
      rh = 8'($urandom);
      wr(`GT2_OFF_RLD_HI, rh);
      wr(`GT2_OFF_CLKSEL, 8'h00);
      // Stopped while preloading, so no tick slips in before suspend
      wr(`GT2_OFF_CTRL, 8'h01);
      set_cnt(8'hfe, 8'hff);
      wr(`GT2_OFF_CTRL, 8'h05);
      wr(`GT2_OFF_POWER, 8'h01);
      cyc(2);
      `TB_CHK(suspended, 1'b1)
      woke = 1'b0;
      for (int i = 0; i < 400 && !woke; i++) begin
         @(posedge hclk);
         woke = (wake_event === 1'b1);
      end
      `TB_CHK(woke, 1'b1)
      cyc(2);
      `TB_CHK(suspended, 1'b0)
      rdx(`GT2_OFF_CNT_HI);
      `TB_CHK(rd, {24'h0, rh})
      done("suspend");

      // Other wake source: sync pending for a few timer clocks
      set_cnt(8'h00, 8'h00);
      wr(`GT2_OFF_POWER, 8'h01);
      cyc(10);
      wake_other <= 1'b1;
      cyc(1);
      wake_other <= 1'b0;
      cyc(3);
      rdx(`GT2_OFF_POWER);
      `TB_CHK(rd[1], 1'b1)
      cyc(300);
      rdx(`GT2_OFF_POWER);
      `TB_CHK(rd, 32'h0)
      done("sync");

      wrap_up;
   end

endmodule : test_general_timer_two_autoreload

`default_nettype wire
